// *** bswc_bank_switch_ctrl.sv ***
// Bank-switch wait logic, bus keeper and bus-off control for external memory
//
// Contract
// [RULE1] A bank crossing within program or data space costs one extra cycle.
// [RULE2] A move from data into program space can cost one wait cycle.
// [RULE3] Bits 15-12 mask the four top address bits; 1111b gives 4K banks.
// [RULE4] Bank sizes from 4K to 64K words follow from the compare mask.
// [RULE5] Bit 11 set adds one cycle between program and data reads.
// [RULE6] Bits 10-3 read zero and ignore writes.
// [RULE7] Bit 2 enables the host-port data keeper and resets to zero.
// [RULE8] Bit 1 enables the external data keeper and resets to zero.
// [RULE9] Bit 0 idles the bus after the current cycle completes.
// [RULE10] While the bus is off, mode and hold bits are write protected.
// [RULE11] The control register sits at data address 0029h.
// [RULE12] Masked upper bits of this and the last access are compared.
`timescale 1ns/100ps
module bswc_bank_switch_ctrl (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic mmr_wr, // Register write strobe
  input wire logic mmr_rd, // Register read strobe
  input wire logic [6:0] mmr_addr, // Memory-mapped register address
  input wire logic [15:0] mmr_wdata, // Write data
  output logic [15:0] mmr_rdata, // Read data, registered
  output logic mmr_hit, // Address selects this register
  output logic pms_wr_allow, // Processor mode status write allowed
  output logic [15:0] pms_wr_mask, // Writable bits of processor mode status
  output logic [15:0] st1_wr_mask, // Writable bits of status_reg_one
  input wire logic req_valid, // CPU external access request
  input wire logic [15:0] req_addr, // Access address
  input wire logic [1:0] req_space, // Access space code
  input wire logic req_read, // Access is a read
  output logic req_ready, // Access accepted this cycle
  output logic bus_active, // External cycle on the pins
  output logic [15:0] ext_addr, // External address
  output logic ext_read, // External read strobe
  output logic [1:0] ext_space, // External space code
  output logic bus_quiet, // Pins inactive due to bus-off
  output logic data_bus_keeper, // External data keeper enable
  output logic host_port_bus_keeper, // Host-port data keeper enable
  output logic gap_cycle // Inserted wait cycle in progress
);
  typedef enum logic [2:0] {
    BSWC_IDLE = 3'b001,
    BSWC_GAP = 3'b010,
    BSWC_RUN = 3'b100
  } bswc_state_t;

  bswc_state_t state_q;
  logic [3:0] bank_compare_mask_q;
  logic prog_data_read_gap_q;
  logic host_keep_q;
  logic data_keep_q;
  logic ext_bus_off_q;
  logic hist_valid_q;
  logic [3:0] prev_top_q;
  logic [1:0] prev_space_q;
  logic prev_read_q;
  logic [15:0] ext_addr_q;
  logic ext_read_q;
  logic [1:0] ext_space_q;
  logic [15:0] rdata_q;
  logic need_gap;
  logic ctrl_sel;
  logic [15:0] ctrl_word;

  // Read view of the control word; reserved bits forced low
  function automatic logic [15:0] bswc_pack(input logic [3:0] m,
      input logic g, input logic h, input logic d, input logic o);
    logic [15:0] w;
    w = bswc_pkg::BSWC_WORD_ZERO;
    w[bswc_pkg::BSWC_CMP_LSB +: 4] = m;
    w[bswc_pkg::BSWC_GAP_BIT] = g;
    w[bswc_pkg::BSWC_HBK_BIT] = h;
    w[bswc_pkg::BSWC_DBK_BIT] = d;
    w[bswc_pkg::BSWC_OFF_BIT] = o;
    return w & bswc_pkg::BSWC_CTRL_MASK; // [RULE6]
  endfunction : bswc_pack

  assign ctrl_sel = (mmr_addr == bswc_pkg::BSWC_CTRL_ADDR); // [RULE11]
  assign ctrl_word = bswc_pack(bank_compare_mask_q, prog_data_read_gap_q,
    host_keep_q, data_keep_q, ext_bus_off_q);

  // Control register fields; reserved write bits are dropped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bank_compare_mask_q <= bswc_pkg::BSWC_CMP_RST;
      prog_data_read_gap_q <= bswc_pkg::BSWC_GAP_RST;
      host_keep_q <= 1'b0; // [RULE7]
      data_keep_q <= 1'b0; // [RULE8]
      ext_bus_off_q <= 1'b0;
    end else if (mmr_wr && ctrl_sel) begin
      bank_compare_mask_q <= mmr_wdata[bswc_pkg::BSWC_CMP_LSB +: 4]; // [RULE3]
      prog_data_read_gap_q <= mmr_wdata[bswc_pkg::BSWC_GAP_BIT]; // [RULE5]
      host_keep_q <= mmr_wdata[bswc_pkg::BSWC_HBK_BIT]; // [RULE7]
      data_keep_q <= mmr_wdata[bswc_pkg::BSWC_DBK_BIT]; // [RULE8]
      ext_bus_off_q <= mmr_wdata[bswc_pkg::BSWC_OFF_BIT]; // [RULE9]
    end
  end

  // Registered read data, zero for other addresses
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_q <= bswc_pkg::BSWC_WORD_ZERO;
    end else if (mmr_rd) begin
      rdata_q <= ctrl_sel ? ctrl_word : bswc_pkg::BSWC_WORD_ZERO; // [RULE6]
    end
  end

  assign mmr_rdata = rdata_q;
  assign mmr_hit = ctrl_sel;

  // Mode and hold bits frozen while the external bus is switched off
  assign pms_wr_allow = !ext_bus_off_q;
  assign pms_wr_mask = ext_bus_off_q ? ~bswc_pkg::BSWC_PMS_PROT :
    16'hFFFF; // [RULE10]
  assign st1_wr_mask = ext_bus_off_q ? ~bswc_pkg::BSWC_ST1_PROT :
    16'hFFFF; // [RULE10]

  assign data_bus_keeper = data_keep_q; // [RULE8]
  assign host_port_bus_keeper = host_keep_q; // [RULE7]

  bswc_cross_detect u_detect (
    .cmp_mask(bank_compare_mask_q),
    .gap_en(prog_data_read_gap_q),
    .hist_valid(hist_valid_q),
    .prev_top(prev_top_q),
    .prev_space(prev_space_q),
    .prev_read(prev_read_q),
    .cur_top(req_addr[15:12]),
    .cur_space(req_space),
    .cur_read(req_read),
    .need_gap(need_gap)
  );

  // Access sequencer: a gap cycle precedes any access that needs one.
  // Bus-off only takes effect from IDLE, so a running cycle always ends.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= BSWC_IDLE;
    end else begin
      case (state_q)
        BSWC_IDLE: begin
          if (req_valid && !ext_bus_off_q) begin // [RULE9]
            state_q <= need_gap ? BSWC_GAP : BSWC_RUN; // [RULE1] [RULE2]
          end
        end
        BSWC_GAP: begin
          state_q <= BSWC_RUN;
        end
        BSWC_RUN: begin
          state_q <= BSWC_IDLE; // [RULE9]
        end
        default: begin
          state_q <= BSWC_IDLE;
        end
      endcase
    end
  end

  // Latch access on the pins when the cycle starts
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ext_addr_q <= bswc_pkg::BSWC_WORD_ZERO;
      ext_read_q <= 1'b0;
      ext_space_q <= bswc_pkg::BSWC_SP_PROG;
    end else if (state_q == BSWC_IDLE && req_valid && !ext_bus_off_q) begin
      ext_addr_q <= req_addr;
      ext_read_q <= req_read;
      ext_space_q <= req_space;
    end
  end

  // History of the last access, kept for the crossing compare
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hist_valid_q <= 1'b0;
      prev_top_q <= 4'h0;
      prev_space_q <= bswc_pkg::BSWC_SP_PROG;
      prev_read_q <= 1'b0;
    end else if (state_q == BSWC_RUN) begin
      hist_valid_q <= 1'b1;
      prev_top_q <= ext_addr_q[15:12]; // [RULE12]
      prev_space_q <= ext_space_q;
      prev_read_q <= ext_read_q;
    end
  end

  // Request is taken when the run cycle completes
  assign req_ready = (state_q == BSWC_RUN);
  assign bus_active = (state_q == BSWC_RUN);
  assign gap_cycle = (state_q == BSWC_GAP);
  // Bus-off idle zeroes the address and keeps the read strobe low; ext_space keeps its last value
  assign bus_quiet = ext_bus_off_q && (state_q == BSWC_IDLE); // [RULE9]
  assign ext_addr = bus_quiet ? bswc_pkg::BSWC_WORD_ZERO : ext_addr_q;
  assign ext_read = bus_active && ext_read_q;
  assign ext_space = ext_space_q;
endmodule : bswc_bank_switch_ctrl

// *** bswc_pkg.sv ***
// Package with register layout and reset values of the bank-switch controller
package bswc_pkg;
  localparam logic [6:0] BSWC_CTRL_ADDR = 7'h29;
  localparam logic [6:0] BSWC_PMS_ADDR = 7'h1D;
  localparam logic [6:0] BSWC_ST1_ADDR = 7'h07;
  localparam int BSWC_CMP_LSB = 12;
  localparam int BSWC_GAP_BIT = 11;
  localparam int BSWC_HBK_BIT = 2;
  localparam int BSWC_DBK_BIT = 1;
  localparam int BSWC_OFF_BIT = 0;
  localparam logic [3:0] BSWC_CMP_RST = 4'hF;
  localparam logic BSWC_GAP_RST = 1'b1;
  localparam logic [15:0] BSWC_CTRL_MASK = 16'hF807;
  localparam logic [15:0] BSWC_PMS_PROT = 16'h0068;
  localparam logic [15:0] BSWC_ST1_PROT = 16'h1000;
  localparam logic [15:0] BSWC_WORD_ZERO = 16'h0000;
  localparam logic [1:0] BSWC_SP_PROG = 2'h0;
  localparam logic [1:0] BSWC_SP_DATA = 2'h1;
  localparam logic [1:0] BSWC_SP_IO = 2'h2;
endpackage : bswc_pkg

// *** bswc_cross_detect.sv ***
// Bank-crossing and read-space-change detector
`timescale 1ns/100ps
module bswc_cross_detect (
  input wire logic [3:0] cmp_mask, // Bank compare mask
  input wire logic gap_en, // Program/data read gap enable
  input wire logic hist_valid, // A previous access is recorded
  input wire logic [3:0] prev_top, // Previous upper address bits
  input wire logic [1:0] prev_space, // Previous access space
  input wire logic prev_read, // Previous access was a read
  input wire logic [3:0] cur_top, // Current upper address bits
  input wire logic [1:0] cur_space, // Current access space
  input wire logic cur_read, // Current access is a read
  output logic need_gap // One idle cycle is owed
);
  logic bank_cross;
  logic read_swap;
  // Masked upper bits disagree within the same program or data space
  assign bank_cross = hist_valid && (prev_space == cur_space) &&
    (cur_space != bswc_pkg::BSWC_SP_IO) &&
    (((prev_top ^ cur_top) & cmp_mask) != 4'h0); // [RULE1] [RULE3] [RULE4] [RULE12]
  // Reads that alternate between program and data space
  assign read_swap = hist_valid && gap_en && prev_read && cur_read &&
    (cur_space != bswc_pkg::BSWC_SP_IO) &&
    (prev_space != bswc_pkg::BSWC_SP_IO) &&
    (prev_space != cur_space); // [RULE2] [RULE5]
  assign need_gap = bank_cross || read_swap;
endmodule : bswc_cross_detect

// *** bswc_ext_mem.sv ***
// External memory model counting cycles seen on the pins
`timescale 1ns/100ps
module bswc_ext_mem (
  input wire logic ref_clk, // Clock
  input wire logic bus_active, // Cycle on pins
  output int n_acc // Cycles seen
);
  // A quiet bus must leave the count alone
  initial n_acc = 0;
  always @(posedge ref_clk) if (bus_active) n_acc <= n_acc + 1;
endmodule : bswc_ext_mem

// *** bswc_bank_switch_ctrl_props.sv ***
// Port assertions for the bank-switch wait controller
`timescale 1ns/100ps
module bswc_bank_switch_ctrl_props (
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset
  input wire logic mmr_rd, // Read
  input wire logic [6:0] mmr_addr, // Address
  input wire logic [15:0] mmr_rdata, // Read data
  input wire logic mmr_hit, // Hit
  input wire logic pms_wr_allow, // Mode write
  input wire logic [15:0] pms_wr_mask, // Mode mask
  input wire logic [15:0] st1_wr_mask, // Status mask
  input wire logic req_ready, // Taken
  input wire logic [15:0] ext_addr, // Pins
  input wire logic bus_quiet, // Bus off
  input wire logic data_bus_keeper, // Keeper
  input wire logic host_port_bus_keeper, // Host keeper
  input wire logic gap_cycle // Wait
);
  // Single domain, so one clock and one disable serve all
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_hit; mmr_hit == (mmr_addr == 7'h29); endproperty
  a_hit: assert property (p_hit) else $error("bad hit");
  property p_resv; mmr_rd && mmr_hit |=> mmr_rdata[10:3] == 8'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_gap; gap_cycle |=> req_ready; endproperty
  a_gap: assert property (p_gap) else $error("gap not one");
  property p_gnr; gap_cycle |-> !req_ready; endproperty
  a_gnr: assert property (p_gnr) else $error("gap with ready");
  property p_off; bus_quiet |-> !req_ready && ext_addr == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("bus not quiet");
  property p_prot; !pms_wr_allow |-> !(|(pms_wr_mask & 16'h0068)); endproperty
  a_prot: assert property (p_prot) else $error("mode open");
  property p_qp; bus_quiet |-> !pms_wr_allow && !st1_wr_mask[12]; endproperty
  a_qp: assert property (p_qp) else $error("status open");
  property p_keep;
    $rose(rstn) |-> !data_bus_keeper && !host_port_bus_keeper;
  endproperty
  a_keep: assert property (p_keep) else $error("keeper set");
  c_gap: cover property (gap_cycle);
  c_off: cover property (bus_quiet);
  c_rd: cover property (mmr_rd && mmr_hit);
endmodule : bswc_bank_switch_ctrl_props
bind bswc_bank_switch_ctrl bswc_bank_switch_ctrl_props u_props (.ref_clk,
  .rstn, .mmr_rd, .mmr_addr, .mmr_rdata, .mmr_hit, .pms_wr_allow,
  .pms_wr_mask, .st1_wr_mask, .req_ready, .ext_addr, .bus_quiet,
  .data_bus_keeper, .host_port_bus_keeper, .gap_cycle);

// *** test_bswc_bank_switch_ctrl.sv ***
// Self-checking bench for the bank-switch wait controller
`timescale 1ns/100ps
module test_bswc_bank_switch_ctrl;
  logic ref_clk = 1'b0, rstn = 1'b0, mmr_wr = 1'b0, mmr_rd = 1'b0;
  logic req_valid = 1'b0, req_read = 1'b0, req_ready, bus_active;
  logic [6:0] mmr_addr = 7'h00;
  logic [15:0] mmr_wdata = 16'h0000, req_addr = 16'h0000, mmr_rdata;
  logic [15:0] pms_wr_mask, st1_wr_mask, ext_addr;
  logic [1:0] req_space = 2'h0, ext_space;
  logic mmr_hit, pms_wr_allow, ext_read, bus_quiet, gap_cycle;
  logic data_bus_keeper, host_port_bus_keeper;
  int failures = 0, compares = 0, n_acc, n0;
  localparam logic [1:0] P = bswc_pkg::BSWC_SP_PROG;
  localparam logic [1:0] D = bswc_pkg::BSWC_SP_DATA;
  localparam logic [6:0] C = bswc_pkg::BSWC_CTRL_ADDR;
  bswc_bank_switch_ctrl dut (.ref_clk, .rstn, .mmr_wr, .mmr_rd, .mmr_addr,
    .mmr_wdata, .mmr_rdata, .mmr_hit, .pms_wr_allow, .pms_wr_mask,
    .st1_wr_mask, .req_valid, .req_addr, .req_space, .req_read, .req_ready,
    .bus_active, .ext_addr, .ext_read, .ext_space, .bus_quiet,
    .data_bus_keeper, .host_port_bus_keeper, .gap_cycle);
  bswc_ext_mem mem (.ref_clk, .bus_active, .n_acc);
  // 4 ns clock
  initial forever #2 ref_clk = ~ref_clk;
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Register strobes last one cycle, inputs move 1 ns after the edge
  task automatic wr(logic [6:0] a, logic [15:0] d);
    mmr_addr = a;
    mmr_wdata = d;
    mmr_wr = 1'b1;
    @(posedge ref_clk) #1 mmr_wr = 1'b0;
  endtask : wr
  task automatic rd(logic [6:0] a, logic [15:0] e);
    mmr_addr = a;
    mmr_rd = 1'b1;
    @(posedge ref_clk) #1 mmr_rd = 1'b0;
    chk("rdata", e, mmr_rdata);
    chk("hit", 16'(a == C), 16'(mmr_hit));
  endtask : rd
  // Hold the request until ready is sampled; e is cycles to ready, 0 none
  task automatic acc(logic [15:0] a, logic [1:0] s, logic r, int e);
    int n;
    int g;
    n = 0;
    g = 0;
    req_addr = a;
    req_space = s;
    req_read = r;
    req_valid = 1'b1;
    do begin
      @(posedge ref_clk) #1 n++;
      if (gap_cycle === 1'b1) g++;
    end while (req_ready !== 1'b1 && n < 8);
    chk("gapcyc", 16'(e == 2), 16'(g));
    if (req_ready === 1'b1) begin
      // Pins carry the request during the run cycle
      chk("addr", a, ext_addr);
      chk("read", 16'(r), 16'(ext_read));
      chk("space", 16'(s), 16'(ext_space));
      chk("active", 16'h1, 16'(bus_active));
    end
    if (req_ready !== 1'b1) n = 0;
    @(posedge ref_clk) #1 req_valid = 1'b0;
    @(posedge ref_clk) #1 chk("latency", 16'(e), 16'(n));
    if (e > 0 && n == 0) test_done();
  endtask : acc
  // Reset image, unmapped place, reserved bits and keepers
  task automatic t_reg;
    chk("keepers", 16'h0, {host_port_bus_keeper, data_bus_keeper});
    rd(C, 16'hF800);
    wr(7'h28, 16'hFFFF);
    rd(7'h28, 16'h0000);
    wr(C, 16'hFFFE);
    rd(C, 16'hF806);
    chk("keepers", 16'h3, {host_port_bus_keeper, data_bus_keeper});
  endtask : t_reg
  // Bank sizes 4K, 32K and 64K
  task automatic t_bank;
    wr(C, 16'hF000);
    acc(16'h0000, P, 1'b1, 1);
    acc(16'h0FFF, P, 1'b1, 1);
    acc(16'h1000, P, 1'b1, 2);
    acc(16'h1000, D, 1'b0, 1);
    acc(16'h2000, D, 1'b0, 2);
    wr(C, 16'h8000);
    acc(16'h7000, D, 1'b0, 1);
    acc(16'h8000, D, 1'b0, 2);
    wr(C, 16'h0000);
    acc(16'h0000, D, 1'b0, 1);
  endtask : t_bank
  // Read gap between spaces, on and off
  task automatic t_gap;
    wr(C, 16'h0800);
    acc(16'h0010, P, 1'b1, 1);
    acc(16'h0020, D, 1'b1, 2);
    acc(16'h0030, P, 1'b1, 2);
    wr(C, 16'h0000);
    acc(16'h0040, D, 1'b1, 1);
  endtask : t_gap
  // Bus off: nothing reaches the pins, mode bits locked
  task automatic t_off;
    wr(C, 16'h0001);
    @(posedge ref_clk) #1 chk("quiet", 16'h1, 16'(bus_quiet));
    chk("pms", 16'h0, pms_wr_mask & 16'h0068);
    chk("st1", 16'h0, st1_wr_mask & 16'h1000);
    chk("allow", 16'h0, 16'(pms_wr_allow));
    n0 = n_acc;
    acc(16'h0050, P, 1'b1, 0);
    chk("pins", 16'(n0), 16'(n_acc));
    wr(C, 16'h0000);
    chk("allow", 16'h1, 16'(pms_wr_allow));
    acc(16'h0060, P, 1'b1, 1);
  endtask : t_off
  // Mid-run reset brings back the reset image and clears the keepers
  task automatic t_rst;
    wr(C, 16'h0807);
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    rd(C, 16'hF800);
    chk("keepers", 16'h0, {host_port_bus_keeper, data_bus_keeper});
    chk("quiet", 16'h0, 16'(bus_quiet));
  endtask : t_rst
  // Reset for 12 cycles, then each scenario in turn
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rstn = 1'b1;
    t_reg();
    t_bank();
    t_gap();
    t_off();
    t_rst();
    test_done();
  end
endmodule : test_bswc_bank_switch_ctrl
